// ### verilog/smsp_pkg.sv
// Shared constants and types of the serial master/slave port
package smsp_pkg;

   // Register addresses on the special-function register port
   localparam logic [7:0] CTRL_ADDR = 8'hF8;
   localparam logic [7:0] DATA_ADDR = 8'hF9;
   localparam logic [7:0] CONFIG_ADDR = 8'hFA;

   // Control/status field positions
   localparam int DONE_BIT = 7;
   localparam int COLL_BIT = 6;
   localparam int FAULT_BIT = 5;
   localparam int OVRN_BIT = 4;
   localparam int BUSY_BIT = 3;
   localparam int SEL_BIT = 2;
   localparam int MASTER_BIT = 1;
   localparam int ON_BIT = 0;

   // Configuration field: frame bit count minus one
   localparam int COUNT_LSB = 0;
   localparam int COUNT_W = 3;

   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 3'h7;

   // Master serial clock half period
   localparam int CLK_PERIOD_NS = 4;
   localparam int SCK_HALF_NS = 16;
   localparam int SCK_HALF_CYCLES =
      (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Master sequencer, Gray along idle-low-high-done
   typedef enum logic [1:0] {
      SMSP_IDLE = 2'b00,
      SMSP_LOW = 2'b01,
      SMSP_HIGH = 2'b11,
      SMSP_DONE = 2'b10
   } smsp_master_e;

endpackage

// ### verilog/smsp_shift_if.sv
// Link between port control and the shift engine
`timescale 1ns/1ns
interface smsp_shift_if;
   logic load;
   logic [7:0] loadData;
   logic start;
   logic shift;
   logic inBit;
   logic outBit;
   logic [7:0] shiftData;
   logic [3:0] bitCount;

   modport ctrl (
      output load,
      output loadData,
      output start,
      output shift,
      output inBit,
      input outBit,
      input shiftData,
      input bitCount
   );

   modport engine (
      input load,
      input loadData,
      input start,
      input shift,
      input inBit,
      output outBit,
      output shiftData,
      output bitCount
   );
endinterface

// ### verilog/smsp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module smsp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   // First stage feeds only the second
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stage1_reg <= INIT;
         stage2_reg <= INIT;
      end else begin
         stage1_reg <= din;
         stage2_reg <= stage1_reg;
      end
   end

   assign dout = stage2_reg;
endmodule

// ### verilog/smsp_shifter.sv
// Eight-bit shift engine, MSB first, with bit counter
`timescale 1ns/1ns
module smsp_shifter (
   input wire logic clk,
   input wire logic reset_n,
   smsp_shift_if.engine sh
);

   logic [7:0] shift_reg;
   logic [3:0] count_reg;

   // Load from the data write, else shift one bit in
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         shift_reg <= smsp_pkg::DATA_RESET;
      end else if (sh.load) begin
         shift_reg <= sh.loadData;
      end else if (sh.shift) begin
         shift_reg <= {shift_reg[6:0], sh.inBit};
      end
   end

   // Bits moved since the transfer started; saturates
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         count_reg <= 4'h0;
      end else if (sh.start) begin
         count_reg <= 4'h0;
      end else if (sh.shift && count_reg != 4'hF) begin
         count_reg <= 4'(count_reg + 4'h1);
      end
   end

   assign sh.outBit = shift_reg[7];
   assign sh.shiftData = shift_reg;
   assign sh.bitCount = count_reg;
endmodule

// ### verilog/smsp_port.sv
// Serial master/slave port with register port and pins
`timescale 1ns/1ns
module smsp_port (
   clk,
   reset_n,
   sfrAddr,
   sfrWrData,
   sfrWrite,
   sfrRead,
   sfrRdData,
   irqReq,
   sckIn,
   sckOut,
   sckOe_n,
   mosiIn,
   mosiOut,
   mosiOe_n,
   misoIn,
   misoOut,
   misoOe_n,
   ssIn_n
);
   input wire logic clk;
   input wire logic reset_n;
   input wire logic [7:0] sfrAddr;
   input wire logic [7:0] sfrWrData;
   input wire logic sfrWrite;
   input wire logic sfrRead;
   output logic [7:0] sfrRdData;
   output logic irqReq;
   input wire logic sckIn;
   output logic sckOut;
   output logic sckOe_n;
   input wire logic mosiIn;
   output logic mosiOut;
   output logic mosiOe_n;
   input wire logic misoIn;
   output logic misoOut;
   output logic misoOe_n;
   input wire logic ssIn_n;

   localparam int HALF = smsp_pkg::SCK_HALF_CYCLES;
   localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

   smsp_shift_if sh ();

   // Pin inputs after two flops
   logic [3:0] pinSync;
   logic sckS;
   logic mosiS;
   logic misoS;
   logic ssS_n;
   logic sckPrev_reg;
   logic ssPrev_reg;
   logic sckRise;
   logic ssFall;
   logic ssRise;

   // Software-visible state
   logic portOn_reg;
   logic master_reg;
   logic done_reg;
   logic done_next;
   logic coll_reg;
   logic coll_next;
   logic fault_reg;
   logic fault_next;
   logic ovrn_reg;
   logic ovrn_next;
   logic [smsp_pkg::COUNT_W-1:0] frameBits_reg;
   logic [7:0] rxBuf_reg;
   logic rxFull_reg;

   // Master sequencer
   smsp_pkg::smsp_master_e state_reg;
   logic [7:0] halfCnt_reg;

   // Decoded strobes and conditions
   logic wrCtrl;
   logic wrData;
   logic wrCfg;
   logic rdData;
   logic masterRole;
   logic slaveRole;
   logic slaveActive;
   logic masterBusy;
   logic masterStart;
   logic collision;
   logic modeFault;
   logic halfDone;
   logic lastBit;
   logic xferEnd;
   logic overrun;

   // Output flops
   logic [7:0] rdData_reg;
   logic irq_reg;
   logic sckOut_reg;
   logic sckOe_n_reg;
   logic mosiOut_reg;
   logic mosiOe_n_reg;
   logic misoOut_reg;
   logic misoOe_n_reg;

   // Idle levels at reset: clock low, select high
   smsp_sync #(.WIDTH(4), .INIT(4'h1)) pinSyncInst (
      .clk(clk),
      .reset_n(reset_n),
      .din({sckIn, mosiIn, misoIn, ssIn_n}),
      .dout(pinSync)
   );

   smsp_shifter shiftInst (
      .clk(clk),
      .reset_n(reset_n),
      .sh(sh)
   );

   assign sckS = pinSync[3];
   assign mosiS = pinSync[2];
   assign misoS = pinSync[1];
   assign ssS_n = pinSync[0];

   // Edge finding works only on already synchronised levels
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sckPrev_reg <= 1'b0;
         ssPrev_reg <= 1'b1;
      end else begin
         sckPrev_reg <= sckS;
         ssPrev_reg <= ssS_n;
      end
   end

   assign sckRise = sckS & ~sckPrev_reg;
   assign ssFall = ~ssS_n & ssPrev_reg;
   assign ssRise = ssS_n & ~ssPrev_reg;

   // Register port decode
   assign wrCtrl = sfrWrite && sfrAddr == smsp_pkg::CTRL_ADDR;
   assign wrData = sfrWrite && sfrAddr == smsp_pkg::DATA_ADDR;
   assign wrCfg = sfrWrite && sfrAddr == smsp_pkg::CONFIG_ADDR;
   assign rdData = sfrRead && sfrAddr == smsp_pkg::DATA_ADDR;

   // Role selection; a disabled port has no role at all
   assign masterRole = portOn_reg & master_reg;
   assign slaveRole = portOn_reg & ~master_reg;
   assign slaveActive = slaveRole & ~ssS_n;
   assign masterBusy = state_reg != smsp_pkg::SMSP_IDLE;

   // Only a master write may launch the sequencer
   assign masterStart = wrData & masterRole & ~masterBusy;
   assign collision = wrData & (masterBusy | slaveActive);
   assign modeFault = masterRole & ~ssS_n;
   assign halfDone = halfCnt_reg == HALF_LAST;
   assign lastBit = sh.bitCount == {1'b0, frameBits_reg};
   assign xferEnd = (state_reg == smsp_pkg::SMSP_DONE) |
                    (slaveRole & ssRise);
   assign overrun = xferEnd & rxFull_reg & ~rdData;

   // Shift engine control; a colliding write never reaches it
   always_comb begin
      sh.load = wrData & ~collision;
      sh.loadData = sfrWrData;
      sh.start = masterStart | (slaveRole & ssFall);
      sh.shift = (state_reg == smsp_pkg::SMSP_HIGH && halfDone) |
                 (slaveActive & sckRise);
      sh.inBit = masterRole ? misoS : mosiS;
   end

   // Master sequencer; leaving master role aborts at once
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg <= smsp_pkg::SMSP_IDLE;
         halfCnt_reg <= 8'h00;
      end else if (!masterRole) begin
         state_reg <= smsp_pkg::SMSP_IDLE;
         halfCnt_reg <= 8'h00;
      end else begin
         case (state_reg)
            smsp_pkg::SMSP_IDLE: begin
               halfCnt_reg <= 8'h00;
               if (masterStart) begin
                  state_reg <= smsp_pkg::SMSP_LOW;
               end
            end
            smsp_pkg::SMSP_LOW: begin
               if (halfDone) begin
                  state_reg <= smsp_pkg::SMSP_HIGH;
                  halfCnt_reg <= 8'h00;
               end else begin
                  halfCnt_reg <= 8'(halfCnt_reg + 8'h01);
               end
            end
            smsp_pkg::SMSP_HIGH: begin
               if (halfDone) begin
                  halfCnt_reg <= 8'h00;
                  if (lastBit) begin
                     state_reg <= smsp_pkg::SMSP_DONE;
                  end else begin
                     state_reg <= smsp_pkg::SMSP_LOW;
                  end
               end else begin
                  halfCnt_reg <= 8'(halfCnt_reg + 8'h01);
               end
            end
            smsp_pkg::SMSP_DONE: begin
               state_reg <= smsp_pkg::SMSP_IDLE;
            end
            default: begin
               state_reg <= smsp_pkg::SMSP_IDLE;
            end
         endcase
      end
   end

   // Sticky flags: a hardware set beats a software clear
   always_comb begin
      done_next = done_reg;
      coll_next = coll_reg;
      fault_next = fault_reg;
      ovrn_next = ovrn_reg;
      if (wrCtrl) begin
         done_next = sfrWrData[smsp_pkg::DONE_BIT];
         coll_next = sfrWrData[smsp_pkg::COLL_BIT];
         fault_next = sfrWrData[smsp_pkg::FAULT_BIT];
         ovrn_next = sfrWrData[smsp_pkg::OVRN_BIT];
      end
      done_next = done_next | xferEnd;
      coll_next = coll_next | collision;
      fault_next = fault_next | modeFault;
      ovrn_next = ovrn_next | overrun;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         done_reg <= smsp_pkg::CTRL_RESET[smsp_pkg::DONE_BIT];
         coll_reg <= smsp_pkg::CTRL_RESET[smsp_pkg::COLL_BIT];
         fault_reg <= smsp_pkg::CTRL_RESET[smsp_pkg::FAULT_BIT];
         ovrn_reg <= smsp_pkg::CTRL_RESET[smsp_pkg::OVRN_BIT];
      end else begin
         done_reg <= done_next;
         coll_reg <= coll_next;
         fault_reg <= fault_next;
         ovrn_reg <= ovrn_next;
      end
   end

   // Control and configuration bits
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         portOn_reg <= smsp_pkg::CTRL_RESET[smsp_pkg::ON_BIT];
         master_reg <= smsp_pkg::CTRL_RESET[smsp_pkg::MASTER_BIT];
         frameBits_reg <= smsp_pkg::COUNT_RESET;
      end else begin
         if (wrCtrl) begin
            portOn_reg <= sfrWrData[smsp_pkg::ON_BIT];
            master_reg <= sfrWrData[smsp_pkg::MASTER_BIT];
         end
         if (wrCfg) begin
            frameBits_reg <= sfrWrData[smsp_pkg::COUNT_LSB +:
                                       smsp_pkg::COUNT_W];
         end
      end
   end

   // Receive buffer; an overrun keeps the older unread byte
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rxBuf_reg <= smsp_pkg::DATA_RESET;
         rxFull_reg <= 1'b0;
      end else if (xferEnd && !overrun) begin
         rxBuf_reg <= sh.shiftData;
         rxFull_reg <= 1'b1;
      end else if (rdData) begin
         rxFull_reg <= 1'b0;
      end
   end

   // Read data, valid the cycle after the read strobe
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdData_reg <= 8'h00;
      end else if (sfrRead) begin
         case (sfrAddr)
            smsp_pkg::CTRL_ADDR: begin
               rdData_reg <= {done_reg, coll_reg, fault_reg, ovrn_reg,
                              masterBusy, ~ssS_n,
                              master_reg, portOn_reg};
            end
            smsp_pkg::DATA_ADDR: begin
               rdData_reg <= rxBuf_reg;
            end
            smsp_pkg::CONFIG_ADDR: begin
               rdData_reg <= {5'h00, frameBits_reg};
            end
            default: begin
               rdData_reg <= 8'h00;
            end
         endcase
      end
   end

   // Request line for the CPU's interrupt controller
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= done_reg | coll_reg | fault_reg | ovrn_reg;
      end
   end

   // Pin drivers; enables are active low, all off when disabled
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sckOut_reg <= 1'b0;
         sckOe_n_reg <= 1'b1;
         mosiOut_reg <= 1'b0;
         mosiOe_n_reg <= 1'b1;
         misoOut_reg <= 1'b0;
         misoOe_n_reg <= 1'b1;
      end else begin
         sckOut_reg <= state_reg == smsp_pkg::SMSP_HIGH;
         sckOe_n_reg <= ~masterRole;
         mosiOut_reg <= sh.outBit;
         mosiOe_n_reg <= ~masterRole;
         misoOut_reg <= sh.outBit;
         misoOe_n_reg <= ~slaveActive;
      end
   end

   assign sfrRdData = rdData_reg;
   assign irqReq = irq_reg;
   assign sckOut = sckOut_reg;
   assign sckOe_n = sckOe_n_reg;
   assign mosiOut = mosiOut_reg;
   assign mosiOe_n = mosiOe_n_reg;
   assign misoOut = misoOut_reg;
   assign misoOe_n = misoOe_n_reg;
endmodule

// ### test/smsp_port_chk.sv
// Pin and register port assertions for the serial port
`timescale 1ns/1ns
module smsp_port_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] sfrAddr,
   input wire logic [7:0] sfrWrData,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   input wire logic [7:0] sfrRdData,
   input wire logic irqReq,
   input wire logic sckIn,
   input wire logic sckOut,
   input wire logic sckOe_n,
   input wire logic mosiIn,
   input wire logic mosiOut,
   input wire logic mosiOe_n,
   input wire logic misoIn,
   input wire logic misoOut,
   input wire logic misoOe_n,
   input wire logic ssIn_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // Status reads of the control register
   logic ctrlRd;
   assign ctrlRd = sfrRead && sfrAddr == smsp_pkg::CTRL_ADDR;

   // Clock only moves while this port drives it
   property p_sckOwn;
      $changed(sckOut) |-> !sckOe_n;
   endproperty
   a_sckOwn: assert property (p_sckOwn) else $error("sck moved undriven");
   // Slave output never beside master outputs
   property p_roles;
      !misoOe_n |-> sckOe_n && mosiOe_n;
   endproperty
   a_roles: assert property (p_roles) else $error("both roles driving");
   // High phase of four cycles
   property p_sckHigh;
      $rose(sckOut) |-> sckOut[*4] ##1 !sckOut;
   endproperty
   a_sckHigh: assert property (p_sckHigh) else $error("sck high width");
   // Low phase at least four cycles
   property p_sckLow;
      $fell(sckOut) |-> !sckOut[*4];
   endproperty
   a_sckLow: assert property (p_sckLow) else $error("sck low width");
   // Data moves only around the falling clock
   property p_mosi;
      $changed(mosiOut) && !mosiOe_n |=> !sckOut;
   endproperty
   a_mosi: assert property (p_mosi) else $error("mosi moved mid bit");
   // Read data holds between reads
   property p_rdHold;
      !$past(sfrRead) |-> $stable(sfrRdData);
   endproperty
   a_rdHold: assert property (p_rdHold) else $error("read data moved");
   // Select flag mirrors a settled select pin
   property p_sel;
      ($stable(ssIn_n) [*5] ##0 ctrlRd)
         |=> sfrRdData[smsp_pkg::SEL_BIT] == !$past(ssIn_n);
   endproperty
   a_sel: assert property (p_sel) else $error("select flag wrong");
   // Busy reads one while the clock is out
   property p_busy;
      ctrlRd && sckOut |=> sfrRdData[smsp_pkg::BUSY_BIT];
   endproperty
   a_busy: assert property (p_busy) else $error("busy flag low");
   // Software-set flags request service
   property p_swSet;
      sfrWrite && sfrAddr == smsp_pkg::CTRL_ADDR && sfrWrData[7:4] != 4'h0
         |-> ##[1:4] irqReq;
   endproperty
   a_swSet: assert property (p_swSet) else $error("no request");
endmodule

bind smsp_port smsp_port_chk u_chk (.clk, .reset_n, .sfrAddr, .sfrWrData,
   .sfrWrite, .sfrRead, .sfrRdData, .irqReq, .sckIn, .sckOut, .sckOe_n,
   .mosiIn, .mosiOut, .mosiOe_n, .misoIn, .misoOut, .misoOe_n, .ssIn_n);

// ### test/smsp_slave_model.sv
// Behavioural external slave facing the port's master role
`timescale 1ns/1ns
module smsp_slave_model (
   input wire logic sckLine,
   input wire logic mosiLine,
   input wire logic sel_n,
   input wire logic [7:0] txByte,
   output logic misoLine,
   output logic [7:0] rxByte
);
   logic [7:0] shiftReg = 8'h00;
   initial misoLine = 1'b0;
   initial rxByte = 8'h00;
   // Reply loaded at select; it never starts a frame itself
   always @(negedge sel_n) begin
      shiftReg = txByte;
      misoLine = txByte[7];
   end
   // Sample on the rising clock
   always @(posedge sckLine) begin
      if (!sel_n) rxByte = {rxByte[6:0], mosiLine};
   end
   // Next bit after the falling clock, MSB first
   always @(negedge sckLine) begin
      if (!sel_n) begin
         shiftReg = {shiftReg[6:0], 1'b0};
         misoLine = shiftReg[7];
      end
   end
   // Released line shows no stale bit
   always @(posedge sel_n) misoLine = ~misoLine;
endmodule

// ### test/smsp_port_tb_top.sv
// Self-checking bench for the serial master/slave port
`timescale 1ns/1ns
module smsp_port_tb_top;
   localparam logic [7:0] CTRL = smsp_pkg::CTRL_ADDR;
   localparam logic [7:0] DATA = smsp_pkg::DATA_ADDR;
   localparam logic [7:0] CFG = smsp_pkg::CONFIG_ADDR;
   logic clk = 0, reset_n = 0, sfrWrite = 0, sfrRead = 0, rdPend = 0;
   logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData, modelRx;
   logic sckExt = 0, mosiExt = 0, ssIn_n = 1, slave_selected_flag_n = 1, modelMiso;
   logic irqReq, sckOut, sckOe_n, mosiOut, mosiOe_n, misoOut, misoOe_n;
   logic sckLine, mosiLine, misoLine;
   logic [7:0] modelTx = 8'h00, tx, sb, a, b, got;
   logic [15:0] expQ[$];
   logic [31:0] seed = 32'h0000_7887;
   int nMismatch = 0, checkCount = 0;

   // Wire levels from the port's enables, else the bench and slave model drivers
   assign sckLine = !sckOe_n ? sckOut : sckExt;
   assign mosiLine = !mosiOe_n ? mosiOut : mosiExt;
   assign misoLine = !misoOe_n ? misoOut : modelMiso;
   always #2 clk = ~clk;

   smsp_port u_dut (.clk(clk), .reset_n(reset_n), .sfrAddr(sfrAddr),
      .sfrWrData(sfrWrData), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
      .sfrRdData(sfrRdData), .irqReq(irqReq), .sckIn(sckLine),
      .sckOut(sckOut), .sckOe_n(sckOe_n), .mosiIn(mosiLine),
      .mosiOut(mosiOut), .mosiOe_n(mosiOe_n), .misoIn(misoLine),
      .misoOut(misoOut), .misoOe_n(misoOe_n), .ssIn_n(ssIn_n));
   smsp_slave_model u_slave (.sckLine(sckLine), .mosiLine(mosiLine),
      .sel_n(slave_selected_flag_n), .txByte(modelTx), .misoLine(modelMiso),
      .rxByte(modelRx));

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // Masked byte compare; em holds mask then value
   task automatic cmp(input logic [7:0] g, input logic [15:0] em);
      checkCount++;
      if ((g & em[15:8]) !== em[7:0]) begin
         nMismatch++;
         $display("unexpected at %0t: got %h want %h", $time, g, em[7:0]);
      end
   endtask
   task automatic stopTest;
      $display("checks %0d mismatches %0d", checkCount, nMismatch);
      if (nMismatch == 0 && checkCount > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(negedge clk);
      sfrAddr = ad;
      sfrWrData = d;
      sfrWrite = 1;
      @(negedge clk);
      sfrWrite = 0;
   endtask
   // Note the expectation, then issue the read
   task automatic rd(input logic [7:0] ad, input logic [7:0] e,
      input logic [7:0] m);
      expQ.push_back({m, e & m});
      @(negedge clk);
      sfrAddr = ad;
      sfrRead = 1;
      @(negedge clk);
      sfrRead = 0;
   endtask
   // Read data lands one cycle after the strobe
   always @(posedge clk) begin
      rdPend <= sfrRead;
      if (rdPend) cmp(sfrRdData, expQ.pop_front());
   end
   // One master frame of n bits against the slave model
   task automatic mxfer(input logic [7:0] t, input logic [7:0] s,
      input int n);
      wr(CFG, 8'(n - 1));
      modelTx = s;
      slave_selected_flag_n = 0;
      wr(DATA, t);
      wr(DATA, ~t);
      repeat (3) @(negedge clk);
      rd(CTRL, 8'h08, 8'h08);
      repeat (8 * n) @(negedge clk);
      slave_selected_flag_n = 1;
      cmp(modelRx, {8'hFF >> (8 - n), t >> (8 - n)});
   endtask
   // External master frame; link clock only inside the frame
   task automatic sframe(input logic [7:0] m, input logic on);
      @(negedge clk);
      ssIn_n = 0;
      repeat (8) @(negedge clk);
      wr(DATA, ~m);
      for (int i = 7; i >= 0; i--) begin
         mosiExt = m[i];
         #16;
         got[i] = misoLine;
         cmp({7'h00, misoOe_n}, {8'hFF, 7'h00, !on});
         sckExt = 1;
         #16;
         sckExt = 0;
      end
      repeat (6) @(negedge clk);
      ssIn_n = 1;
      repeat (8) @(negedge clk);
   endtask

   // Hang guard; a stuck run is a failed run
   initial begin
      #200000;
      nMismatch++;
      $display("unexpected at %0t: run timed out", $time);
      stopTest();
   end
   initial begin
      repeat (2) @(negedge clk);
      reset_n = 1;
      repeat (3) @(negedge clk);
      rd(CTRL, 8'h00, 8'hFF);
      rd(CFG, 8'h07, 8'hFF);
      rd(DATA, 8'h00, 8'hFF);
      rd(8'h10, 8'h00, 8'hFF);
      wr(CTRL, 8'h03);
      for (int n = 1; n <= 8; n++) begin
         tx = rnd();
         sb = rnd();
         mxfer(tx, sb, n);
         rd(CTRL, 8'hC3, 8'hFF);
         cmp({7'h00, irqReq}, {8'hFF, 8'h01});
         rd(DATA, 8'(tx << n) | 8'(sb >> (8 - n)), 8'hFF);
         wr(CTRL, 8'h03);
      end
      a = rnd();
      b = rnd();
      mxfer(a, b, 8);
      mxfer(rnd(), rnd(), 8);
      rd(CTRL, 8'hD3, 8'hFF);
      rd(DATA, b, 8'hFF);
      wr(CTRL, 8'h03);
      ssIn_n = 0;
      repeat (8) @(negedge clk);
      rd(CTRL, 8'h27, 8'hFF);
      ssIn_n = 1;
      repeat (6) @(negedge clk);
      wr(CTRL, 8'hF1);
      rd(CTRL, 8'hF1, 8'hFF);
      wr(CTRL, 8'h01);
      sb = rnd();
      tx = rnd();
      wr(DATA, sb);
      sframe(tx, 1);
      cmp(got, {8'hFF, sb});
      rd(CTRL, 8'hC1, 8'hFF);
      rd(DATA, tx, 8'hFF);
      wr(CTRL, 8'h00);
      sframe(rnd(), 0);
      rd(CTRL, 8'h00, 8'hF8);
      repeat (4) @(negedge clk);
      stopTest();
   end
endmodule
